// *** inc/adcrc_pkg.sv ***
// Purpose: Shared constants for the converter register and control block
// Assumes: 32-bit AHB-Lite slave, registers on aligned words
// Notes: Register offsets are byte addresses within the block's window
package adcrc_pkg;

   // Register map
   localparam logic [3:0] REG_CSR_OFS = 4'h0;
   localparam logic [3:0] REG_RESULT_OFS = 4'h4;
   localparam logic [3:0] REG_CLKSEL_OFS = 4'h8;
   localparam int unsigned OFS_W = 4;

   // Control/status fields
   localparam int unsigned CSR_FLAG_BIT = 7;
   localparam int unsigned CSR_IRQEN_BIT = 6;
   localparam int unsigned CSR_CONT_BIT = 5;
   localparam int unsigned CSR_CH_LSB = 0;
   localparam int unsigned CH_W = 5;
   localparam logic [7:0] CSR_RESET = 8'h1f;

   // Clock select fields
   localparam int unsigned CLKSEL_DIV_LSB = 5;
   localparam int unsigned DIV_W = 3;
   localparam logic [DIV_W-1:0] CLKSEL_RESET = 3'h0;

   // Channel codes
   localparam logic [CH_W-1:0] CH_PA0 = 5'h00;
   localparam logic [CH_W-1:0] CH_PA1 = 5'h01;
   localparam logic [CH_W-1:0] CH_PA4 = 5'h02;
   localparam logic [CH_W-1:0] CH_PA5 = 5'h03;
   localparam logic [CH_W-1:0] CH_REF_HIGH = 5'h1d;
   localparam logic [CH_W-1:0] CH_REF_LOW = 5'h1e;
   localparam logic [CH_W-1:0] CH_OFF = 5'h1f;

   // Conversion timing, in converter clock ticks
   localparam int unsigned CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_SAMPLE_LAST = 4'h7;
   localparam logic [CNT_W-1:0] CNT_LAST = 4'hf;
   localparam logic [7:0] SAR_MSB = 8'h80;

   // AHB-Lite
   localparam int unsigned TRANS_ACTIVE_BIT = 1;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARM = 2'b01,
      ST_CONV = 2'b11
   } adcrc_state_e;

   function automatic logic [CNT_W-1:0] div_limit(input logic [DIV_W-1:0] sel);
      case (sel)
         3'h0: div_limit = 4'h0;
         3'h1: div_limit = 4'h1;
         3'h2: div_limit = 4'h3;
         3'h3: div_limit = 4'h7;
         default: div_limit = 4'hf;
      endcase
   endfunction

   function automatic logic reg_hit(input logic [OFS_W-1:0] ofs,
                                    input logic [OFS_W-1:0] reg_ofs);
      reg_hit = (ofs == reg_ofs);
   endfunction

endpackage

// *** src/adcrc_clk_div.sv ***
// Purpose: Converter clock prescaler, one-cycle tick per converter clock
// Assumes: Single bus clock domain
// Notes: Counter parks at zero while the converter is powered off
`timescale 1ns/1ns
module adcrc_clk_div
   import adcrc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic run,
   input wire logic [DIV_W-1:0] div_sel,
   output logic tick
);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   // Compare with >= so a smaller ratio written mid-count does not wait a wrap
   assign tick = run && (cnt_r >= div_limit(div_sel));

   always_comb begin
      if (!run || tick) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + 4'h1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule // adcrc_clk_div

// *** src/adcrc_sar.sv ***
// Purpose: Successive-approximation sequencer, sixteen ticks per conversion
// Assumes: cmp_hi is already synchronised; high when input >= dac_code
// Notes: Ticks 0..7 sample, ticks 8..15 resolve one bit each, MSB first
`timescale 1ns/1ns
module adcrc_sar
   import adcrc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic tick,
   input wire logic go,
   input wire logic abort,
   input wire logic cmp_hi,
   output logic busy,
   output logic done,
   output logic sample_en,
   output logic [7:0] dac_code,
   output logic [7:0] result
);

   logic busy_r, busy_nxt;
   logic done_r, done_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [7:0] code_r, code_nxt;
   logic [7:0] res_r, res_nxt;

   always_comb begin
      logic [2:0] bitpos;
      logic [7:0] trial;
      bitpos = 3'h0;
      trial = code_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      cnt_nxt = cnt_r;
      code_nxt = code_r;
      res_nxt = res_r;
      if (abort) begin
         busy_nxt = 1'b0;
         cnt_nxt = '0;
         code_nxt = '0;
      end else if (go) begin
         busy_nxt = 1'b1;
         cnt_nxt = '0;
         code_nxt = '0;
      end else if (busy_r && tick) begin
         cnt_nxt = cnt_r + 4'h1;
         if (cnt_r == CNT_SAMPLE_LAST) begin
            code_nxt = SAR_MSB;
         end else if (cnt_r > CNT_SAMPLE_LAST) begin
            bitpos = 3'(CNT_LAST - cnt_r);
            if (!cmp_hi) begin
               trial[bitpos] = 1'b0;
            end
            if (bitpos != 3'h0) begin
               trial[bitpos - 3'h1] = 1'b1;
            end
            code_nxt = trial;
         end
         if (cnt_r == CNT_LAST) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            res_nxt = trial;
            cnt_nxt = '0;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
         cnt_r <= '0;
         code_r <= '0;
         res_r <= '0;
      end else begin
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         cnt_r <= cnt_nxt;
         code_r <= code_nxt;
         res_r <= res_nxt;
      end
   end

   assign busy = busy_r;
   assign done = done_r;
   assign sample_en = busy_r && (cnt_r <= CNT_SAMPLE_LAST);
   assign dac_code = code_r;
   assign result = res_r;

endmodule // adcrc_sar

// *** src/adcrc_top.sv ***
// Purpose: Register and control logic of an 8-bit four-channel SAR converter
// Assumes: AHB-Lite slave on the bus clock; analog core outside the domain
// Notes: Every access takes one wait state so read data leave a register
//
// Operation
// - Flag sets per conversion, read of result clears
// - Interrupt mode: flag never sets, reads zero
// - Interrupt mode raises request after each conversion
// - Result read or status write drops request
// - Reset clears interrupt enable
// - Continuous mode repeats, reloading result each time
// - Single mode converts once; reset clears continuous
// - Codes 0..3 route port A pins 0,1,4,5
// - All-ones channel code powers converter down
// - Reset sets channel code to all ones
// - Codes 1d/1e select high/low references
// - Unused channel codes give undefined results
// - One 8-bit result, loaded per completion
// - Prescaler divides bus clock 1,2,4,8,16
// - Conversion lasts sixteen converter clocks
// - Start on first converter clock after write
// - Continuous mode overwrites unread results
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module adcrc_top
   import adcrc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic cmp_hi_pin,
   output logic core_power_en,
   output logic sample_en,
   output logic [7:0] dac_code,
   output logic port_a_bit0_sel,
   output logic port_a_bit1_sel,
   output logic port_a_bit4_sel,
   output logic port_a_bit5_sel,
   output logic ref_high_sel,
   output logic ref_low_sel,
   output logic conv_irq
);

   // Comparator from the analog core
   logic cmp_meta_r;
   logic cmp_sync_r;

   // Bus data-phase state
   logic act_r, act_nxt;
   logic wr_r, wr_nxt;
   logic word_r, word_nxt;
   logic [OFS_W-1:0] ofs_r, ofs_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic addr_take;

   // Register contents and control
   adcrc_state_e state_r, state_nxt;
   logic conv_irq_enable_r, conv_irq_enable_nxt;
   logic continuous_convert_r, continuous_convert_nxt;
   logic [CH_W-1:0] channel_select_r, channel_select_nxt;
   logic conv_complete_flag_r, conv_complete_flag_nxt;
   logic irq_r, irq_nxt;
   logic [DIV_W-1:0] clock_divider_select_r, clock_divider_select_nxt;
   logic [7:0] result_r, result_nxt;

   // Decoded events
   logic wr_csr;
   logic wr_clksel;
   logic rd_result;
   logic powered;
   logic go;
   logic abort;
   logic tick;
   logic sar_busy;
   logic sar_done;
   logic [7:0] sar_result;
   logic [7:0] csr_view;
   logic [CH_W-1:0] wr_channel;

   // Two-stage synchroniser; only the second stage feeds logic
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cmp_meta_r <= 1'b0;
         cmp_sync_r <= 1'b0;
      end else begin
         cmp_meta_r <= cmp_hi_pin;
         cmp_sync_r <= cmp_meta_r;
      end
   end

   // Bus slave

   // Address phase is taken only while the bus is ready
   assign addr_take = hsel && hready && htrans[TRANS_ACTIVE_BIT];

   // Flag shows zero whenever interrupt mode is on
   assign csr_view = {conv_complete_flag_r && !conv_irq_enable_r,
                      conv_irq_enable_r,
                      continuous_convert_r,
                      channel_select_r};

   always_comb begin
      act_nxt = addr_take;
      wr_nxt = wr_r;
      word_nxt = word_r;
      ofs_nxt = ofs_r;
      hrdata_nxt = hrdata_r;
      if (addr_take) begin
         wr_nxt = hwrite;
         word_nxt = (hsize == HSIZE_WORD);
         ofs_nxt = haddr[OFS_W-1:0];
      end
      if (act_r && !wr_r) begin
         case (ofs_r)
            REG_CSR_OFS: begin
               hrdata_nxt = {24'h0, csr_view};
            end
            REG_RESULT_OFS: begin
               hrdata_nxt = {24'h0, result_r};
            end
            REG_CLKSEL_OFS: begin
               hrdata_nxt = {24'h0, clock_divider_select_r, 5'h00};
            end
            default: begin
               hrdata_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         act_r <= 1'b0;
         wr_r <= 1'b0;
         word_r <= 1'b0;
         ofs_r <= '0;
         hrdata_r <= '0;
      end else begin
         act_r <= act_nxt;
         wr_r <= wr_nxt;
         word_r <= word_nxt;
         ofs_r <= ofs_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   // One wait state per access gives registered read data
   assign hreadyout = !act_r;
   assign hrdata = hrdata_r;
   // No error responses: unmapped offsets read zero, writes vanish
   assign hresp = HRESP_OKAY;

   // Register side effects

   // Writes act in the wait cycle, the first cycle in which hwdata is valid
   assign wr_csr = act_r && wr_r && word_r && reg_hit(ofs_r, REG_CSR_OFS);
   assign wr_clksel = act_r && wr_r && word_r && reg_hit(ofs_r, REG_CLKSEL_OFS);
   assign rd_result = act_r && !wr_r && reg_hit(ofs_r, REG_RESULT_OFS);
   assign wr_channel = hwdata[CSR_CH_LSB +: CH_W];
   // Power-off code also parks the prescaler and the sequencer
   assign powered = (channel_select_r != CH_OFF);

   always_comb begin
      state_nxt = state_r;
      go = 1'b0;
      abort = 1'b0;
      conv_irq_enable_nxt = conv_irq_enable_r;
      continuous_convert_nxt = continuous_convert_r;
      channel_select_nxt = channel_select_r;
      clock_divider_select_nxt = clock_divider_select_r;
      result_nxt = result_r;
      conv_complete_flag_nxt = conv_complete_flag_r;
      irq_nxt = irq_r;

      case (state_r)
         ST_IDLE: begin
            // Reads never re-arm; only a status write starts work
            state_nxt = ST_IDLE;
         end
         ST_ARM: begin
            // Waiting for a tick keeps every start on a converter clock edge
            if (tick && powered) begin
               go = 1'b1;
               state_nxt = ST_CONV;
            end
         end
         ST_CONV: begin
            if (sar_done) begin
               // Continuous re-arms; single shot stops
               state_nxt = continuous_convert_r ? ST_ARM : ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase

      // A status write aborts any conversion and re-arms on the new setup, unless the new channel code is all ones
      if (wr_csr) begin
         go = 1'b0;
         abort = 1'b1;
         state_nxt = (wr_channel != CH_OFF) ? ST_ARM : ST_IDLE;
         conv_irq_enable_nxt = hwdata[CSR_IRQEN_BIT];
         continuous_convert_nxt = hwdata[CSR_CONT_BIT];
         channel_select_nxt = wr_channel;
         // Flag position of the write is ignored
      end
      if (wr_clksel) begin
         clock_divider_select_nxt = hwdata[CLKSEL_DIV_LSB +: DIV_W];
      end

      // Result changes only on completion, read or not
      if (sar_done) begin
         result_nxt = sar_result;
      end

      // Set beats a clear arriving in the same cycle
      if (sar_done && !conv_irq_enable_r) begin
         conv_complete_flag_nxt = 1'b1;
      end else if (rd_result) begin
         conv_complete_flag_nxt = 1'b0;
      end
      if (conv_irq_enable_nxt) begin
         conv_complete_flag_nxt = 1'b0;
      end

      // A completion racing a clear keeps the request, so none is lost
      if (sar_done && conv_irq_enable_r) begin
         irq_nxt = 1'b1;
      end else if (rd_result || wr_csr) begin
         irq_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= ST_IDLE;
         conv_irq_enable_r <= CSR_RESET[CSR_IRQEN_BIT];
         continuous_convert_r <= CSR_RESET[CSR_CONT_BIT];
         channel_select_r <= CSR_RESET[CSR_CH_LSB +: CH_W];
         conv_complete_flag_r <= CSR_RESET[CSR_FLAG_BIT];
         irq_r <= 1'b0;
         clock_divider_select_r <= CLKSEL_RESET;
         result_r <= '0;
      end else begin
         state_r <= state_nxt;
         conv_irq_enable_r <= conv_irq_enable_nxt;
         continuous_convert_r <= continuous_convert_nxt;
         channel_select_r <= channel_select_nxt;
         conv_complete_flag_r <= conv_complete_flag_nxt;
         irq_r <= irq_nxt;
         clock_divider_select_r <= clock_divider_select_nxt;
         result_r <= result_nxt;
      end
   end

   assign conv_irq = irq_r;

   // Analog routing. Unused and reserved codes leave every select low, so
   // the core converts a floating node and the result is don't-care
   assign core_power_en = powered;
   assign port_a_bit0_sel = (channel_select_r == CH_PA0);
   assign port_a_bit1_sel = (channel_select_r == CH_PA1);
   assign port_a_bit4_sel = (channel_select_r == CH_PA4);
   assign port_a_bit5_sel = (channel_select_r == CH_PA5);
   assign ref_high_sel = (channel_select_r == CH_REF_HIGH);
   assign ref_low_sel = (channel_select_r == CH_REF_LOW);

   // Prescaler stops while powered off to save power
   adcrc_clk_div u_clk_div (
      .clk(clk),
      .reset(reset),
      .run(powered),
      .div_sel(clock_divider_select_r),
      .tick(tick)
   );

   // Comparator sync adds two bus cycles; at divide-by-1 the core must
   // settle each trial within that latency, so low ratios trade accuracy
   adcrc_sar u_sar (
      .clk(clk),
      .reset(reset),
      .tick(tick),
      .go(go),
      .abort(abort),
      .cmp_hi(cmp_sync_r),
      .busy(sar_busy),
      .done(sar_done),
      .sample_en(sample_en),
      .dac_code(dac_code),
      .result(sar_result)
   );

endmodule // adcrc_top

// *** bench/adcrc_top_assertions.sv ***
// Purpose: Port-level checks of the converter register block
// Assumes: One bus clock, asynchronous active-high reset
// Notes: Register side effects are visible two edges after the address edge
`timescale 1ns/1ns
module adcrc_top_assertions
   import adcrc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic cmp_hi_pin,
   input wire logic core_power_en,
   input wire logic sample_en,
   input wire logic [7:0] dac_code,
   input wire logic port_a_bit0_sel,
   input wire logic port_a_bit1_sel,
   input wire logic port_a_bit4_sel,
   input wire logic port_a_bit5_sel,
   input wire logic ref_high_sel,
   input wire logic ref_low_sel,
   input wire logic conv_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   wire logic acc = hsel && hready && htrans[TRANS_ACTIVE_BIT];
   wire logic rd_acc = acc && !hwrite;
   wire logic csr_wr = acc && hwrite && hsize == HSIZE_WORD && haddr[3:0] == REG_CSR_OFS;
   wire logic res_rd = rd_acc && haddr[3:0] == REG_RESULT_OFS;
   wire logic [5:0] sels = {ref_low_sel, ref_high_sel, port_a_bit5_sel, port_a_bit4_sel,
      port_a_bit1_sel, port_a_bit0_sel};
   a_resp_okay: assert property (hresp == HRESP_OKAY)
      else $error("bus response not okay");
   a_one_wait: assert property (acc |=> !hreadyout ##1 hreadyout)
      else $error("access did not take exactly one wait state");
   a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   // Read data may only move as a read completes
   a_rdata_change: assert property ($changed(hrdata) |-> $past(rd_acc, 2) || $past(rd_acc, 3))
      else $error("read data changed without a read");
   a_off_idle: assert property (!core_power_en |-> !sample_en)
      else $error("sampling while powered off");
   a_sel_onehot: assert property ($onehot0(sels))
      else $error("more than one input selected");
   a_sel_power: assert property (|sels |-> core_power_en)
      else $error("input selected while powered off");
   a_irq_wr_clear: assert property (csr_wr |-> ##3 !conv_irq)
      else $error("request stayed after status write");
   a_irq_rd_clear: assert property (res_rd |-> ##3 !conv_irq)
      else $error("request stayed after result read");
   a_irq_rise: assert property ($rose(conv_irq) |-> core_power_en && !sample_en)
      else $error("request raised outside a conversion end");
endmodule // adcrc_top_assertions

bind adcrc_top adcrc_top_assertions chk (.clk(clk), .reset(reset), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
   .cmp_hi_pin(cmp_hi_pin), .core_power_en(core_power_en), .sample_en(sample_en),
   .dac_code(dac_code), .port_a_bit0_sel(port_a_bit0_sel),
   .port_a_bit1_sel(port_a_bit1_sel), .port_a_bit4_sel(port_a_bit4_sel),
   .port_a_bit5_sel(port_a_bit5_sel), .ref_high_sel(ref_high_sel),
   .ref_low_sel(ref_low_sel), .conv_irq(conv_irq));

// *** bench/adcrc_core_model.sv ***
// Purpose: Analog multiplexer and comparator standing in for the core
// Assumes: One input level per select line, set by the bench
// Notes: Unselected or unpowered, the comparator toggles every cycle
`timescale 1ns/1ns
module adcrc_core_model (
   input wire logic clk,
   input wire logic core_power_en,
   input wire logic [7:0] dac_code,
   input wire logic [5:0] sels,
   output logic cmp_hi
);
   logic [7:0] vin [0:5];
   logic [7:0] v;
   initial cmp_hi = 1'b0;
   always_comb begin
      v = 8'h00;
      for (int i = 0; i < 6; i++)
         if (sels[i]) v = vin[i];
   end
   // Toggling keeps a dead input from looking like a stable level
   always @(posedge clk) begin
      if (core_power_en && |sels)
         cmp_hi <= v >= dac_code;
      else
         cmp_hi <= ~cmp_hi;
   end
endmodule // adcrc_core_model

// *** bench/test_adc_register_control.sv ***
// Purpose: Register-level test of the converter control block
// Assumes: Single AHB-Lite master, hready fed back from hreadyout
// Notes: Accurate results need the slow dividers; fast ones check timing only
`timescale 1ns/1ns
module test_adc_register_control
   import adcrc_pkg::*;
;
   logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic hreadyout, hresp, cmp_hi_pin, core_power_en, sample_en, conv_irq, s_d = 1'b0;
   logic [7:0] dac_code;
   logic [5:0] sels;
   logic [7:0] tbl [0:5] = '{8'h5a, 8'hc3, 8'h17, 8'ha8, 8'hff, 8'h00};
   logic [4:0] chs [0:5] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1d, 5'h1e};
   int err_count = 0, comparisons = 0, nconv = 0, scnt = 0, k, s;
   adcrc_top dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cmp_hi_pin(cmp_hi_pin),
      .core_power_en(core_power_en), .sample_en(sample_en), .dac_code(dac_code),
      .port_a_bit0_sel(sels[0]), .port_a_bit1_sel(sels[1]), .port_a_bit4_sel(sels[2]),
      .port_a_bit5_sel(sels[3]), .ref_high_sel(sels[4]), .ref_low_sel(sels[5]),
      .conv_irq(conv_irq));
   adcrc_core_model ana (.clk(clk), .core_power_en(core_power_en), .dac_code(dac_code),
      .sels(sels), .cmp_hi(cmp_hi_pin));
   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      s_d <= sample_en;
      if (sample_en === 1'b1) scnt <= scnt + 1;
      if (sample_en === 1'b1 && s_d !== 1'b1) nconv <= nconv + 1;
   end
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Wide enough for the status bit or event count packed beside a word
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tmo(input bit bad);
      if (bad) begin
         err_count++;
         $display("Error at %0t: wait ran out", $time);
         summarize();
      end
   endtask
   // hready judged mid-cycle, so the edge sample is settled
   task automatic hwait();
      logic ok;
      int n;
      ok = 1'b0;
      for (n = 0; n < 20 && !ok; n++) begin
         @(negedge clk);
         ok = (hreadyout === 1'b1);
         @(posedge clk);
      end
      tmo(!ok);
   endtask
   task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {28'h0, a};
      hsize <= HSIZE_WORD;
      hwait();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      hwait();
      // Taken at the edge that sees hready high, before it updates anything
      rv = hrdata;
   endtask
   task automatic wait_flag();
      int n;
      rv = 32'h0;
      for (n = 0; n < 300 && rv[CSR_FLAG_BIT] !== 1'b1; n++)
         xfer(1'b0, REG_CSR_OFS, 8'h00);
      tmo(n == 300);
   endtask
   task automatic wait_ev(input bit irq, input int lim);
      int n;
      for (n = 0; n < 2000 && (irq ? conv_irq !== 1'b1 : nconv < lim); n++)
         @(posedge clk);
      tmo(n == 2000);
   endtask
   initial begin
      for (int i = 0; i < 6; i++)
         ana.vin[i] = tbl[i];
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      xfer(1'b0, REG_RESULT_OFS, 8'h00);
      chk(rv, 32'h0);
      xfer(1'b0, REG_CSR_OFS, 8'h00);
      chk(rv, 32'h1f);
      chk(core_power_en, 1'b0);
      xfer(1'b0, 4'hc, 8'h00);
      chk(rv, 32'h0);
      // Last pass uses code 7: any code with the top bit set divides by 16
      for (int c = 0; c < 5; c++) begin
         s = (c == 4) ? 7 : c;
         xfer(1'b1, REG_CLKSEL_OFS, 8'(s << CLKSEL_DIV_LSB) | 8'h1f);
         xfer(1'b0, REG_CLKSEL_OFS, 8'h00);
         chk(rv, 32'(s << CLKSEL_DIV_LSB));
         s = scnt;
         xfer(1'b1, REG_CSR_OFS, 8'h00);
         wait_flag();
         chk(scnt - s, 8 << c);
         xfer(1'b0, REG_RESULT_OFS, 8'h00);
      end
      for (int i = 0; i < 6; i++) begin
         xfer(1'b1, REG_CSR_OFS, {3'b000, chs[i]});
         chk(sels, 6'h01 << i);
         wait_flag();
         k = nconv;
         xfer(1'b0, REG_RESULT_OFS, 8'h00);
         chk(rv, tbl[i]);
         xfer(1'b0, REG_CSR_OFS, 8'h00);
         chk(rv, {3'b000, chs[i]});
         repeat (400) @(posedge clk);
         xfer(1'b0, REG_RESULT_OFS, 8'h00);
         chk({nconv - k, rv}, {32'h0, 24'h0, tbl[i]});
      end
      xfer(1'b1, REG_CSR_OFS, 8'h21);
      k = nconv;
      wait_ev(1'b0, k + 2);
      ana.vin[1] = 8'h3c;
      wait_ev(1'b0, k + 4);
      xfer(1'b0, REG_CSR_OFS, 8'h00);
      chk(rv, 32'ha1);
      xfer(1'b0, REG_RESULT_OFS, 8'h00);
      chk(rv, 32'h3c);
      xfer(1'b1, REG_CSR_OFS, 8'h1f);
      k = nconv;
      repeat (600) @(posedge clk);
      chk({core_power_en, nconv}, {1'b0, k});
      // First result after power-up is only for settling
      xfer(1'b1, REG_CSR_OFS, 8'h00);
      wait_flag();
      xfer(1'b1, REG_CSR_OFS, 8'h40);
      wait_ev(1'b1, 0);
      xfer(1'b0, REG_CSR_OFS, 8'h00);
      chk({conv_irq, rv}, {1'b1, 32'h40});
      xfer(1'b0, REG_RESULT_OFS, 8'h00);
      chk({conv_irq, rv}, {1'b0, 24'h0, tbl[0]});
      xfer(1'b1, REG_CSR_OFS, 8'h40);
      wait_ev(1'b1, 0);
      xfer(1'b1, REG_CSR_OFS, 8'h5f);
      chk(conv_irq, 1'b0);
      summarize();
   end
endmodule // test_adc_register_control
